//--- dac_pkg.sv
// dac_pkg: constants shared by the data address compare debug block
// assumes a 32-bit AHB-Lite register bus and little-endian bit numbering (lsb = 0) in the field descriptions
package dac_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] DAC_OFS_CMP_A = 8'h00;
	localparam logic [7:0] DAC_OFS_CMP_B = 8'h04;
	localparam logic [7:0] DAC_OFS_CTRL = 8'h08;
	localparam logic [7:0] DAC_OFS_STATUS = 8'h0C;
	localparam logic [7:0] DAC_OFS_RET = 8'h10;
	localparam logic [7:0] DAC_OFS_MASK = 8'h14;

	// ==========================================================
	// control register fields (bit positions, lsb = 0)
	localparam int DAC_CTL_RD_A = 0;
	localparam int DAC_CTL_WR_A = 1;
	localparam int DAC_CTL_RD_B = 2;
	localparam int DAC_CTL_WR_B = 3;
	localparam int DAC_CTL_GRAN_A = 4;
	localparam int DAC_CTL_GRAN_B = 6;
	localparam int DAC_CTL_RANGE = 8;
	localparam int DAC_CTL_POL = 9;
	localparam int DAC_CTL_VCMP_A = 10;
	localparam int DAC_CTL_VCMP_B = 11;
	localparam int DAC_CTL_DBGIE = 12;
	localparam int DAC_CTL_WIDTH = 13;

	// ==========================================================
	// status register fields
	localparam int DAC_ST_RD_A = 0;
	localparam int DAC_ST_WR_A = 1;
	localparam int DAC_ST_RD_B = 2;
	localparam int DAC_ST_WR_B = 3;
	localparam int DAC_ST_WIDTH = 4;

	// ==========================================================
	// reset values
	localparam logic [31:0] DAC_RST_CMP = 32'h0000_0000;
	localparam logic [DAC_CTL_WIDTH-1:0] DAC_RST_CTRL = 13'h0000;
	localparam logic [DAC_ST_WIDTH-1:0] DAC_RST_STATUS = 4'h0;

	// granularity codes
	typedef enum logic [1:0] {
		DAC_GRAN_BYTE = 2'b00,
		DAC_GRAN_HALF = 2'b01,
		DAC_GRAN_WORD = 2'b10,
		DAC_GRAN_LINE = 2'b11
	} dac_gran_t;

	// address masks, ones where a bit takes part
	localparam logic [31:0] DAC_MASK_BYTE = 32'hFFFF_FFFF;
	localparam logic [31:0] DAC_MASK_HALF = 32'hFFFF_FFFE;
	localparam logic [31:0] DAC_MASK_WORD = 32'hFFFF_FFFC;
	localparam logic [31:0] DAC_MASK_LINE = 32'hFFFF_FFE0;

	// AHB-Lite encodings
	localparam logic [1:0] DAC_HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] DAC_HSIZE_WORD = 3'b010;

endpackage

//--- dac_addr_match.sv
// dac_addr_match: two exact compares and one range evaluation of one effective address
// assumes purely combinational use inside the comparator top
`timescale 1ns/10ps
module dac_addr_match
	import dac_pkg::*;
(
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_cmp_a,
	input wire logic [31:0] i_cmp_b,
	input wire logic [1:0] i_gran_a,
	input wire logic [1:0] i_gran_b,
	input wire logic i_polarity,
	output logic o_exact_a,
	output logic o_exact_b,
	output logic o_range
);

	// granularity code to compare mask
	function automatic logic [31:0] gran_mask(input logic [1:0] code);
		logic [31:0] m;
		m = DAC_MASK_BYTE;
		unique case (dac_gran_t'(code))
			DAC_GRAN_BYTE: m = DAC_MASK_BYTE;
			DAC_GRAN_HALF: m = DAC_MASK_HALF;
			DAC_GRAN_WORD: m = DAC_MASK_WORD;
			DAC_GRAN_LINE: m = DAC_MASK_LINE;
		endcase
		return m;
	endfunction

	// ==========================================================
	// exact compares, mask applied to both sides
	wire logic [31:0] mask_a = gran_mask(i_gran_a);
	wire logic [31:0] mask_b = gran_mask(i_gran_b);
	assign o_exact_a = (i_addr & mask_a) == (i_cmp_a & mask_a);
	assign o_exact_b = (i_addr & mask_b) == (i_cmp_b & mask_b);

	// ==========================================================
	// range: full addresses, granularity ignored
	wire logic in_window = (i_addr >= i_cmp_a) && (i_addr < i_cmp_b);
	assign o_range = i_polarity ? !in_window : in_window;

endmodule

//--- dac_compare.sv
// dac_compare: data address compare debug unit with AHB-Lite registers
// assumes the load/store pipeline presents one effective address per cycle
// and drives multi-address accesses as a series of beats
`timescale 1ns/10ps
module dac_compare
	import dac_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	// load/store pipeline side
	input wire logic i_acc_valid,
	input wire logic i_acc_write,
	input wire logic [31:0] i_acc_addr,
	input wire logic [31:0] i_acc_inst_addr,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// debug outputs
	output logic o_dbg_event,
	output logic o_irq
);

	// ==========================================================
	// registers
	logic [31:0] cmp_a_q;
	logic [31:0] cmp_b_q;
	logic [DAC_CTL_WIDTH-1:0] ctrl_q;
	logic [DAC_ST_WIDTH-1:0] status_q;
	logic [DAC_ST_WIDTH-1:0] status_d;
	logic [DAC_ST_WIDTH-1:0] mask_q;
	logic [31:0] ret_q;
	logic event_q;
	logic [31:0] hrdata_q;
	// bus data phase bookkeeping
	logic wr_pend_q;
	logic [7:0] wr_ofs_q;

	// ==========================================================
	// control field decode
	wire logic rd_en_a = ctrl_q[DAC_CTL_RD_A];
	wire logic wr_en_a = ctrl_q[DAC_CTL_WR_A];
	wire logic rd_en_b = ctrl_q[DAC_CTL_RD_B];
	wire logic wr_en_b = ctrl_q[DAC_CTL_WR_B];
	wire logic [1:0] gran_a = ctrl_q[DAC_CTL_GRAN_A +: 2];
	wire logic [1:0] gran_b = ctrl_q[DAC_CTL_GRAN_B +: 2];
	wire logic range_mode = ctrl_q[DAC_CTL_RANGE];
	wire logic range_pol = ctrl_q[DAC_CTL_POL];
	wire logic vcmp_a = ctrl_q[DAC_CTL_VCMP_A];
	wire logic vcmp_b = ctrl_q[DAC_CTL_VCMP_B];
	wire logic dbg_ie = ctrl_q[DAC_CTL_DBGIE];

	// ==========================================================
	// address evaluation, one beat per cycle
	logic exact_a;
	logic exact_b;
	logic range_hit;

	dac_addr_match u_match (
		.i_addr(i_acc_addr),
		.i_cmp_a(cmp_a_q),
		.i_cmp_b(cmp_b_q),
		.i_gran_a(gran_a),
		.i_gran_b(gran_b),
		.i_polarity(range_pol),
		.o_exact_a(exact_a),
		.o_exact_b(exact_b),
		.o_range(range_hit)
	);

	// per register address hit; range mode replaces exact mode
	wire logic addr_hit_a = range_mode ? range_hit : exact_a;
	wire logic addr_hit_b = range_mode ? range_hit : exact_b;
	// value compare enable blocks the address hit of its register; no data value stage follows
	wire logic ev_ok_a = addr_hit_a && !vcmp_a;
	wire logic ev_ok_b = addr_hit_b && !vcmp_b;
	// every valid beat is checked, so multi-address accesses need no extra state
	wire logic is_rd = i_acc_valid && !i_acc_write;
	wire logic is_wr = i_acc_valid && i_acc_write;

	// hit vector in status layout; range mode sets the enabled bits of a direction for each register whose value compare is off
	wire logic [DAC_ST_WIDTH-1:0] hits = {
		is_wr && wr_en_b && ev_ok_b,
		is_rd && rd_en_b && ev_ok_b,
		is_wr && wr_en_a && ev_ok_a,
		is_rd && rd_en_a && ev_ok_a
	};
	wire logic any_hit = |hits;

	// ==========================================================
	// AHB-Lite decode; zero wait states, always OKAY
	wire logic bus_take = i_hsel && i_hready && i_htrans[1];
	wire logic bus_rd = bus_take && !i_hwrite;
	wire logic bus_wr = bus_take && i_hwrite;
	wire logic [7:0] bus_ofs = i_haddr[7:0];
	wire logic st_read = bus_rd && (bus_ofs == DAC_OFS_STATUS);

	// read mux, unmapped reads as zero
	wire logic [31:0] rd_mux =
		(bus_ofs == DAC_OFS_CMP_A) ? cmp_a_q :
		(bus_ofs == DAC_OFS_CMP_B) ? cmp_b_q :
		(bus_ofs == DAC_OFS_CTRL) ? {19'h00000, ctrl_q} :
		(bus_ofs == DAC_OFS_STATUS) ? {28'h0000000, status_q} :
		(bus_ofs == DAC_OFS_RET) ? ret_q :
		(bus_ofs == DAC_OFS_MASK) ? {28'h0000000, mask_q} :
		32'h0000_0000;

	// status: read clears, a new hit in the same cycle wins; no other clearing
	assign status_d = (st_read ? DAC_RST_STATUS : status_q) | hits;

	assign o_hrdata = hrdata_q;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_dbg_event = event_q;
	assign o_irq = |(status_q & mask_q);

	// ==========================================================
	// address phase capture for writes, read data into flop
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_pend_q <= 1'b0;
			wr_ofs_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= bus_wr;
			wr_ofs_q <= bus_ofs;
			hrdata_q <= bus_rd ? rd_mux : hrdata_q;
		end
	end

	// software writable registers, written in the data phase
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cmp_a_q <= DAC_RST_CMP;
			cmp_b_q <= DAC_RST_CMP;
			ctrl_q <= DAC_RST_CTRL;
			mask_q <= DAC_RST_STATUS;
		end else if (wr_pend_q) begin
			if (wr_ofs_q == DAC_OFS_CMP_A) cmp_a_q <= i_hwdata;
			if (wr_ofs_q == DAC_OFS_CMP_B) cmp_b_q <= i_hwdata;
			if (wr_ofs_q == DAC_OFS_CTRL) ctrl_q <= i_hwdata[DAC_CTL_WIDTH-1:0];
			if (wr_ofs_q == DAC_OFS_MASK) mask_q <= i_hwdata[DAC_ST_WIDTH-1:0];
		end
	end

	// sticky status, event pulse and return address capture
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			status_q <= DAC_RST_STATUS;
			event_q <= 1'b0;
			ret_q <= 32'h0000_0000;
		end else begin
			status_q <= status_d;
			event_q <= any_hit;
			if (any_hit && dbg_ie) ret_q <= i_acc_inst_addr;
		end
	end

	// ==========================================================
	// checks
	sequence s_hit_seen;
		any_hit;
	endsequence

	a_event_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_hit_seen |=> o_dbg_event && (status_q != DAC_RST_STATUS))
		else $error("event pulse missing after hit");

	a_status_sticky: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!$past(st_read) && !$past(any_hit)) |-> status_q == $past(status_q))
		else $error("status changed without hit or read");

	a_exact_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(range_mode && i_acc_valid && !range_hit) |=> !o_dbg_event)
		else $error("exact hit raised in range mode");

	a_dir_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
		is_wr |-> (hits[DAC_ST_RD_A] == 1'b0) && (hits[DAC_ST_RD_B] == 1'b0))
		else $error("write set a read status bit");

	a_dir_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
		is_rd |-> (hits[DAC_ST_WR_A] == 1'b0) && (hits[DAC_ST_WR_B] == 1'b0))
		else $error("read set a write status bit");

	a_ret_capture: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(any_hit && dbg_ie) |=> ret_q == $past(i_acc_inst_addr))
		else $error("return address not captured");

	a_vcmp_block: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(vcmp_a && vcmp_b) |-> !any_hit)
		else $error("address event while value compare on");

	a_range_incl: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(range_mode && !range_pol && is_rd && rd_en_a && !vcmp_a
		 && i_acc_addr >= cmp_a_q && i_acc_addr < cmp_b_q) |=> status_q[DAC_ST_RD_A])
		else $error("inclusive range read missed");

	a_range_excl: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(range_mode && range_pol && is_wr && wr_en_b && !vcmp_b
		 && i_acc_addr >= cmp_a_q && i_acc_addr < cmp_b_q) |-> !hits[DAC_ST_WR_B])
		else $error("exclusive range matched inside window");

	a_exact_word: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!range_mode && gran_a == 2'b10 && is_rd && rd_en_a && !vcmp_a
		 && i_acc_addr[31:2] == cmp_a_q[31:2]) |-> hits[DAC_ST_RD_A])
		else $error("word granular match missed");

	// ==========================================================
	// further checks: granularity, range bounds and gating
	// named steps shared by the multi-cycle checks below
	sequence s_two_hits;
		any_hit ##1 any_hit;
	endsequence

	sequence s_quiet_read;
		st_read && !any_hit;
	endsequence

	// back to back beats of one access each raise their own pulse
	a_beat_series: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_two_hits |-> o_dbg_event ##1 o_dbg_event)
		else $error("second beat of an access lost its event");

	// a status read without a new hit leaves nothing behind
	a_read_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_quiet_read |=> status_q == DAC_RST_STATUS)
		else $error("status read did not clear");

	// no pulse without a hitting beat, no hit without a beat
	a_no_event: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!any_hit |=> !o_dbg_event)
		else $error("event pulse without a hit");

	a_valid_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!i_acc_valid |-> !any_hit)
		else $error("hit without an access beat");

	// exact mode with byte granularity: a hit sets its bit and pulses
	a_exact_status: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!range_mode && gran_a == DAC_GRAN_BYTE && is_rd && rd_en_a && !vcmp_a
		 && i_acc_addr == cmp_a_q) |=> status_q[DAC_ST_RD_A] && o_dbg_event)
		else $error("exact byte read hit not recorded");

	// enables combine: register b being armed too must not hide register a
	a_exact_pair: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!range_mode && gran_a == DAC_GRAN_BYTE && is_wr && wr_en_a && wr_en_b && !vcmp_a
		 && i_acc_addr == cmp_a_q) |-> hits[DAC_ST_WR_A])
		else $error("exact write hit lost with both enables set");

	a_exact_byte: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!range_mode && gran_a == DAC_GRAN_BYTE && i_acc_valid
		 && i_acc_addr != cmp_a_q) |-> !hits[DAC_ST_RD_A] && !hits[DAC_ST_WR_A])
		else $error("byte granular compare matched another address");

	a_exact_half: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!range_mode && gran_a == DAC_GRAN_HALF && is_wr && wr_en_a && !vcmp_a
		 && i_acc_addr[31:1] == cmp_a_q[31:1]) |-> hits[DAC_ST_WR_A])
		else $error("halfword granular match missed");

	a_exact_line: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!range_mode && gran_a == DAC_GRAN_LINE && is_wr && wr_en_a && !vcmp_a
		 && i_acc_addr[31:5] == cmp_a_q[31:5]) |-> hits[DAC_ST_WR_A])
		else $error("cacheline granular match missed");

	// the second register follows its own field, not the first one
	a_gran_word_b: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!range_mode && gran_b == DAC_GRAN_WORD && is_rd && rd_en_b && !vcmp_b
		 && i_acc_addr[31:2] == cmp_b_q[31:2]) |-> hits[DAC_ST_RD_B])
		else $error("word granular match on register b missed");

	a_gran_line_b: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!range_mode && gran_b == DAC_GRAN_LINE && is_wr && wr_en_b && !vcmp_b
		 && i_acc_addr[31:5] == cmp_b_q[31:5]) |-> hits[DAC_ST_WR_B])
		else $error("cacheline match on register b missed");

	a_miss_word_b: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!range_mode && gran_b == DAC_GRAN_WORD && i_acc_valid
		 && i_acc_addr[31:2] != cmp_b_q[31:2]) |-> !hits[DAC_ST_RD_B] && !hits[DAC_ST_WR_B])
		else $error("word granular compare on register b matched another word");

	// range mode: full addresses, enables pick the status bits
	a_range_full: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(range_mode && !range_pol && is_wr && wr_en_b && !vcmp_b
		 && i_acc_addr >= cmp_a_q && i_acc_addr < cmp_b_q) |-> hits[DAC_ST_WR_B])
		else $error("range write inside window missed");

	a_range_enable: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(range_mode && is_rd && !rd_en_b) |-> !hits[DAC_ST_RD_B])
		else $error("range read set a disabled status bit");

	a_range_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(range_mode && range_pol && is_wr && wr_en_a && !vcmp_a
		 && i_acc_addr >= cmp_b_q) |-> hits[DAC_ST_WR_A])
		else $error("exclusive range write above window missed");

	a_range_below: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(range_mode && range_pol && is_rd && rd_en_a && !vcmp_a
		 && i_acc_addr < cmp_a_q) |-> hits[DAC_ST_RD_A])
		else $error("exclusive range read below window missed");

	a_range_outside: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(range_mode && !range_pol && i_acc_valid
		 && (i_acc_addr < cmp_a_q || i_acc_addr >= cmp_b_q)) |-> !any_hit)
		else $error("inclusive range matched outside window");

	// value compare takes the address event of its own register only
	a_vcmp_a_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
		vcmp_a |-> !hits[DAC_ST_RD_A] && !hits[DAC_ST_WR_A])
		else $error("register a event while its value compare on");

	a_vcmp_b_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
		vcmp_b |-> !hits[DAC_ST_RD_B] && !hits[DAC_ST_WR_B])
		else $error("register b event while its value compare on");

	// return register moves only on a hit with debug interrupts on
	a_ret_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!(any_hit && dbg_ie) |=> $stable(ret_q))
		else $error("return address changed without a hit");

endmodule

//--- dac_lsu_model.sv
// dac_lsu_model: load/store pipeline model that feeds effective address beats
// assumes the bench calls beat on consecutive edges for multi-address accesses
`timescale 1ns/10ps
module dac_lsu_model (
	input wire logic i_core_clk,
	output logic o_acc_valid,
	output logic o_acc_write,
	output logic [31:0] o_acc_addr,
	output logic [31:0] o_acc_inst_addr
);
	// ==========================================================
	// beat driver
	initial begin
		o_acc_valid = 1'b0;
		o_acc_write = 1'b0;
		o_acc_addr = 32'h0;
		o_acc_inst_addr = 32'h0;
	end

	// one address per beat, no gaps inside one access
	task automatic beat(input logic [31:0] a, input logic w, input logic [31:0] ia);
		@(posedge i_core_clk);
		o_acc_valid <= 1'b1;
		o_acc_write <= w;
		o_acc_addr <= a;
		o_acc_inst_addr <= ia;
	endtask

	// released lines show the inverse so stale values never look valid
	task automatic idle();
		@(posedge i_core_clk);
		o_acc_valid <= 1'b0;
		o_acc_write <= ~o_acc_write;
		o_acc_addr <= ~o_acc_addr;
		o_acc_inst_addr <= ~o_acc_inst_addr;
	endtask
endmodule

//--- dac_compare_tb.sv
// dac_compare_tb: self-checking bench for the data address compare unit
// assumes dac_lsu_model drives the access port and one AHB-Lite slave
`timescale 1ns/10ps
module dac_compare_tb import dac_pkg::*; ();
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, aa, ai, ca, cb;
	logic [31:0] ret = 32'h0;
	logic hready, hresp, ev, irq, av, aw;
	logic v_d = 1'b0;
	logic [12:0] ctl;
	logic [3:0] st, msk;
	int err_total = 0;
	int checks = 0;
	logic exp_q [$];
	// masks per granularity code, ones where a bit takes part
	logic [31:0] gm [4] = '{32'hFFFF_FFFF, 32'hFFFF_FFFE, 32'hFFFF_FFFC, 32'hFFFF_FFE0};
	logic [12:0] cfg [9] = '{13'h104F, 13'h00E9, 13'h10B6, 13'h11F9, 13'h030F, 13'h050F, 13'h085F, 13'h00F0,
		13'h1C3F};

	always #4 clk = ~clk;

	dac_compare u_dut (.i_core_clk(clk), .i_rst(rst), .i_acc_valid(av), .i_acc_write(aw), .i_acc_addr(aa),
		.i_acc_inst_addr(ai), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(DAC_HSIZE_WORD), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp), .o_dbg_event(ev), .o_irq(irq));
	dac_lsu_model u_lsu (.i_core_clk(clk), .o_acc_valid(av), .o_acc_write(aw), .o_acc_addr(aa),
		.o_acc_inst_addr(ai));

	// ==========================================================
	// checking and bus tasks
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// both phases wait on hready, so slave wait states are tolerated
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= DAC_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		hsel <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		cmp(nm, e, r);
		cmp("hresp", 32'h0, {31'h0, hresp});
	endtask

	// ==========================================================
	// reference hit calculation from control and compare shadows
	function automatic logic [3:0] ref_hit(input logic [31:0] x, input logic w);
		logic ha, hb;
		if (ctl[8]) begin
			ha = ((x >= ca) && (x < cb)) ^ ctl[9];
			hb = ha;
		end else begin
			ha = (x & gm[ctl[5:4]]) == (ca & gm[ctl[5:4]]);
			hb = (x & gm[ctl[7:6]]) == (cb & gm[ctl[7:6]]);
		end
		ha = ha & !ctl[10];
		hb = hb & !ctl[11];
		return {hb & w & ctl[3], hb & !w & ctl[2], ha & w & ctl[1], ha & !w & ctl[0]};
	endfunction

	// driver notes the expected event before launching the beat
	task automatic send(input logic [31:0] x, input logic w);
		logic [31:0] ia;
		logic [3:0] h;
		ia = $urandom;
		h = ref_hit(x, w);
		st = st | h;
		if ((h != 4'h0) && ctl[12]) ret = ia;
		exp_q.push_back(h != 4'h0);
		u_lsu.beat(x, w, ia);
	endtask

	// event watcher, sampled mid-cycle to stay clear of the edge
	always @(posedge clk) v_d <= av;
	always @(negedge clk) begin
		if (v_d && exp_q.size() > 0) cmp("event", {31'h0, exp_q.pop_front()}, {31'h0, ev});
		else if (!rst) cmp("idle event", 32'h0, {31'h0, ev});
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] ad [10];
		void'($urandom(32'hFA2F9E34));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd("ctrl rst", DAC_OFS_CTRL, {19'h0, DAC_RST_CTRL});
		rd("status rst", DAC_OFS_STATUS, {28'h0, DAC_RST_STATUS});
		rd("cmp rst", DAC_OFS_CMP_B, DAC_RST_CMP);
		rd("unmapped", 8'h18, 32'h0);
		for (int i = 0; i < 9; i++) begin
			ctl = cfg[i];
			msk = i[0] ? 4'hF : 4'h5;
			st = 4'h0;
			ca = $urandom & 32'h7FFF_FFFF;
			cb = ca + ($urandom & 32'hFF) + 32'h1;
			wr(DAC_OFS_CMP_A, ca);
			wr(DAC_OFS_CMP_B, cb);
			wr(DAC_OFS_CTRL, {19'h0, ctl});
			wr(DAC_OFS_MASK, {28'h0, msk});
			ad = '{ca, ca ^ 32'h1, ca ^ 32'h2, ca ^ 32'h10, ca ^ 32'h20, ca - 32'h1, cb, cb - 32'h1, cb ^ 32'h1, $urandom};
			for (int w = 0; w < 2; w++) foreach (ad[k]) send(ad[k], w[0]);
			for (int k = 0; k < 4; k++) send((ca & 32'hFFFF_FFFC) + 32'(4 * k), 1'b0);
			u_lsu.idle();
			repeat (2) @(posedge clk);
			cmp("irq", {31'h0, |(st & msk)}, {31'h0, irq});
			rd("status", DAC_OFS_STATUS, {28'h0, st});
			rd("status clr", DAC_OFS_STATUS, 32'h0);
			rd("ret", DAC_OFS_RET, ret);
			rd("ctrl", DAC_OFS_CTRL, {19'h0, ctl});
			$display("test %0d done", i);
		end
		complete_run();
	end

	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#100000;
		err_total++;
		complete_run();
	end
endmodule
